// [hw/ocr_defines.svh]
`ifndef OCR_DEFINES_SVH
`define OCR_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the host port)
// ----------------------------------------------------------------
`define OCR_ADDR_W        8
`define OCR_OFS_CTRL      8'h60
`define OCR_OFS_FREQ      8'h61
`define OCR_OFS_GROUP     8'h62
`define OCR_OFS_FINE      8'h63
`define OCR_OFS_PAGE      8'h64
`define OCR_OFS_MODE_LO   8'h65
`define OCR_OFS_MODE_HI   8'h66

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OCR_RST_CTRL      8'hA3
`define OCR_RST_FREQ      8'h55
`define OCR_RST_GROUP     8'h00
`define OCR_RST_FINE      8'hFF
`define OCR_RST_PAGE      8'h00
`define OCR_RST_MODE_LO   8'h00
`define OCR_RST_MODE_HI   8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OCR_BIT_DIFF_EN   1
`define OCR_ADJ_HI        7
`define OCR_ADJ_LO        6
`define OCR_SEL_HI        6
`define OCR_SEL_LO        4
`define OCR_BIT_GROUP     0

// ----------------------------------------------------------------
// legal pages of the extended window
// ----------------------------------------------------------------
`define OCR_PG_GENERAL    8'h00
`define OCR_PG_FREERUN    8'h01
`define OCR_PG_SYNC1HZ    8'h08
`define OCR_PG_TOP        8'h0A
`define OCR_PG_IRQ        8'h0F

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OCR_CLK_PS        10000
`define OCR_ADJ_STEP_PS   1600
`define OCR_FINE_STEP_FS  119200

`endif

// [hw/ocr_pkg.sv]
// ----------------------------------------------------------------
// types shared by the output clock register bank
// ----------------------------------------------------------------
package ocr_pkg;

    // frequency mode of one reference input
    typedef enum logic [1:0] {
        OCR_MODE_AUTO     = 2'h0,
        OCR_MODE_CUSTOM_A = 2'h1,
        OCR_MODE_CUSTOM_B = 2'h2,
        OCR_MODE_RSVD     = 2'h3
    } ocr_ref_mode_e;

    // one host port request
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // byte address
        logic [7:0] wdata; // write data
    } ocr_req_s;

    // differential pin triple
    typedef struct packed {
        logic p;  // true leg
        logic n;  // complement leg
        logic oe; // leg drivers on
    } ocr_diff_s;

endpackage

// [hw/ocr_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// divider: square wave whose half period is set by i_half
// ----------------------------------------------------------------
module ocr_clk_div #(
    parameter int W = 5 // counter width
) (
    input  wire logic         i_ref_clk, // system clock
    input  wire logic         i_rst_n,   // synchronous-released reset
    input  wire logic         i_en,      // run the divider
    input  wire logic [W-1:0] i_half,    // half period in cycles
    output logic              o_level    // divided level
);
    typedef struct packed {
        logic [W-1:0] cnt; // cycles into half period
        logic         lvl; // output level
    } ocr_div_s;

    ocr_div_s st;      // registered state
    ocr_div_s next_st; // next state

    // count and toggle at each half period end
    always_comb begin
        next_st = st;
        if (!i_en) begin
            next_st.cnt = '0;
            next_st.lvl = 1'b0;
        end else if (st.cnt >= i_half - W'(1)) begin
            next_st.cnt = '0;
            next_st.lvl = ~st.lvl;
        end else begin
            next_st.cnt = st.cnt + W'(1);
        end
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.lvl;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_div_half: assert property (i_en && $stable(i_half) && $changed(st.lvl)
        && i_half == W'(3) |-> ##1 (!$changed(st.lvl) || !i_en) [*2])
        else $error("half period too short");
endmodule

`default_nettype wire

// [hw/ocr_align_dly.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// alignment line: a tap per adjust step, low code is earliest
// ----------------------------------------------------------------
module ocr_align_dly #(
    parameter int STEP = 1 // cycles per code step
) (
    input  wire logic       i_ref_clk, // system clock
    input  wire logic       i_rst_n,   // synchronous-released reset
    input  wire logic       i_in,      // undelayed level
    input  wire logic [1:0] i_code,    // adjust code
    output logic            o_out      // delayed level
);
    localparam int LEN = 4 * STEP; // line length

    typedef struct packed {
        logic [LEN-1:0] line; // shift line
        logic           out;  // chosen tap
    } ocr_dly_s;

    ocr_dly_s st;      // registered state
    ocr_dly_s next_st; // next state

    // shift and pick the tap
    always_comb begin
        next_st = st;
        next_st.line = {st.line[LEN-2:0], i_in};
        next_st.out = st.line[int'(i_code) * STEP];
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_out = st.out;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_dly_early: assert property ($stable(i_code)[*4] ##0 i_code == 2'h0
        |-> o_out == $past(i_in, 2)) else $error("code zero delay wrong");

    a_dly_late: assert property ($stable(i_code)[*6] ##0 (i_code == 2'h3 && STEP == 1)
        |-> o_out == $past(i_in, 5)) else $error("code three delay wrong");
endmodule

`default_nettype wire

// [hw/ocr_regs.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ocr_defines.svh"

// Notes on behaviour
// - enable bit drives diff, else high impedance
// - adjust field steps diff timing 1.6 ns; here each step is one 10 ns clock cycle
// - lower adjust code earlier, higher later
// - adjust reset value gives specified alignment
// - select field picks diff output frequency
// - signed fine phase feeds both paths
// - page selector maps five legal pages only
// - two-bit mode per reference, codes 0-3
// - group bit picks high or low speed
module ocr_regs #(
    parameter int DIV_W = 5 // divider counter width
) (
    input  wire logic                i_ref_clk,     // 100 MHz clock
    input  wire logic                i_rst_b,       // async reset, low
    input  wire ocr_pkg::ocr_req_s   i_req,         // host request
    output logic [7:0]               o_rdata,       // read data
    output ocr_pkg::ocr_diff_s       o_diff,        // diff pin triple
    output logic signed [7:0]        o_apll_fine,   // analog path phase
    output logic signed [7:0]        o_synth_fine,  // synthesizer phase
    output logic [7:0]               o_page,        // selected page
    output logic                     o_page_rsvd,   // page not legal
    output ocr_pkg::ocr_ref_mode_e [4:0] o_ref_mode, // per reference
    output logic [4:0]               o_mode_rsvd,   // mode code 3
    output logic                     o_low_group    // low speed group
);
    import ocr_pkg::*;

    // ----------------------------------------------------------------
    // timing constants
    // ----------------------------------------------------------------
    // cycles per adjust step, rounded down, at least one
    localparam int STEP_RAW = `OCR_ADJ_STEP_PS / `OCR_CLK_PS;
    localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_q; // release shifter
    logic       rst_n; // released reset

    // release the reset through two flops
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    assign rst_n = rst_q[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;    // diff output control
        logic [7:0] freq;    // diff output frequency
        logic [7:0] grp;     // frequency group
        logic [7:0] fine;    // fine phase offset
        logic [7:0] page;    // extended page select
        logic [7:0] mode_lo; // modes of refs 0-3
        logic [7:0] mode_hi; // mode of ref 4
        logic [7:0] rdata;   // read data
        logic       p;       // true leg
        logic       n;       // complement leg
    } ocr_st_s;

    ocr_st_s st;      // registered state
    ocr_st_s next_st; // next state

    logic             div_lvl;  // divided level
    logic             dly_lvl;  // aligned level
    logic [DIV_W-1:0] half;     // half period

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // true for a mapped offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a >= `OCR_OFS_CTRL) && (a <= `OCR_OFS_MODE_HI);
    endfunction

    // true for a legal extended page
    function automatic logic page_ok(input logic [7:0] pg);
        page_ok = (pg == `OCR_PG_GENERAL) || (pg == `OCR_PG_FREERUN)
               || (pg == `OCR_PG_SYNC1HZ) || (pg == `OCR_PG_TOP)
               || (pg == `OCR_PG_IRQ);
    endfunction

    // read value of one offset
    function automatic logic [7:0] rd_val(input ocr_st_s s, input logic [7:0] a);
        case (a)
            `OCR_OFS_CTRL:    rd_val = s.ctrl;
            `OCR_OFS_FREQ:    rd_val = s.freq;
            `OCR_OFS_GROUP:   rd_val = s.grp;
            `OCR_OFS_FINE:    rd_val = s.fine;
            `OCR_OFS_PAGE:    rd_val = s.page;
            `OCR_OFS_MODE_LO: rd_val = s.mode_lo;
            `OCR_OFS_MODE_HI: rd_val = s.mode_hi;
            default:          rd_val = 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    // full bytes are stored, reserved bits included
    always_comb begin
        next_st = st;
        if (i_req.wr && is_mapped(i_req.addr)) begin
            case (i_req.addr)
                `OCR_OFS_CTRL:    next_st.ctrl = i_req.wdata;
                `OCR_OFS_FREQ:    next_st.freq = i_req.wdata;
                `OCR_OFS_GROUP:   next_st.grp = i_req.wdata;
                `OCR_OFS_FINE:    next_st.fine = i_req.wdata;
                `OCR_OFS_PAGE:    next_st.page = i_req.wdata;
                `OCR_OFS_MODE_LO: next_st.mode_lo = i_req.wdata;
                `OCR_OFS_MODE_HI: next_st.mode_hi = i_req.wdata;
                default:          next_st.page = st.page;
            endcase
        end
        // read data stand one cycle, zero otherwise
        next_st.rdata = i_req.rd ? rd_val(st, i_req.addr) : 8'h00;
        next_st.p = st.ctrl[`OCR_BIT_DIFF_EN] & dly_lvl;
        next_st.n = st.ctrl[`OCR_BIT_DIFF_EN] & ~dly_lvl;
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st.ctrl    <= `OCR_RST_CTRL;
            st.freq    <= `OCR_RST_FREQ;
            st.grp     <= `OCR_RST_GROUP;
            st.fine    <= `OCR_RST_FINE;
            st.page    <= `OCR_RST_PAGE;
            st.mode_lo <= `OCR_RST_MODE_LO;
            st.mode_hi <= `OCR_RST_MODE_HI;
            st.rdata   <= 8'h00;
            st.p       <= 1'b0;
            st.n       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // differential clock path
    // ----------------------------------------------------------------
    // select and group set the half period
    assign half = DIV_W'({st.grp[`OCR_BIT_GROUP], st.freq[`OCR_SEL_HI:`OCR_SEL_LO]})
                + DIV_W'(1);

    ocr_clk_div #(
        .W (DIV_W)
    ) u_div (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_en      (st.ctrl[`OCR_BIT_DIFF_EN]),
        .i_half    (half),
        .o_level   (div_lvl)
    );

    ocr_align_dly #(
        .STEP (STEP_CYC)
    ) u_dly (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_in      (div_lvl),
        .i_code    (st.ctrl[`OCR_ADJ_HI:`OCR_ADJ_LO]),
        .o_out     (dly_lvl)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rdata = st.rdata;
    assign o_diff.p = st.p;
    assign o_diff.n = st.n;
    assign o_diff.oe = st.ctrl[`OCR_BIT_DIFF_EN];
    assign o_apll_fine = signed'(st.fine);
    assign o_synth_fine = signed'(st.fine);
    assign o_page = st.page;
    assign o_page_rsvd = ~page_ok(st.page);
    assign o_low_group = st.grp[`OCR_BIT_GROUP];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_ref_mode[i] = ocr_ref_mode_e'(st.mode_lo[2*i +: 2]);
        end
        o_ref_mode[4] = ocr_ref_mode_e'(st.mode_hi[1:0]);
        for (int i = 0; i < 5; i++) begin
            o_mode_rsvd[i] = (o_ref_mode[i] == OCR_MODE_RSVD);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    // each write check looks one cycle past the taking edge
    // legs lag the enable by one register, hence the past terms

    a_diff_oe_follow: assert property (i_req.wr && i_req.addr == `OCR_OFS_CTRL
        |=> o_diff.oe == $past(i_req.wdata[1])) else $error("enable not taken");

    a_diff_off_low: assert property (!o_diff.oe [*2]
        |-> !o_diff.p && !o_diff.n) else $error("legs move while off");

    a_legs_invert: assert property ($past(o_diff.oe) && $past(rst_n)
        |-> o_diff.n == !o_diff.p) else $error("legs not complementary");

    a_oe_reset: assert property ($rose(rst_n)
        |-> o_diff.oe) else $error("enable reset wrong");

    a_adj_reset: assert property ($rose(rst_n)
        |-> st.ctrl[7:6] == 2'h2) else $error("adjust reset wrong");

    a_sel_write: assert property (i_req.wr && i_req.addr == `OCR_OFS_FREQ
        |=> half == DIV_W'({st.grp[0], $past(i_req.wdata[6:4])}) + DIV_W'(1))
        else $error("select not applied");

    a_sel_reset: assert property ($rose(rst_n)
        |-> st.freq[`OCR_SEL_HI:`OCR_SEL_LO] == 3'h5) else $error("select reset wrong");

    a_fine_both: assert property (i_req.wr && i_req.addr == `OCR_OFS_FINE
        |=> o_apll_fine == $past(i_req.wdata) && o_synth_fine == o_apll_fine)
        else $error("fine phase mismatch");

    a_fine_reset: assert property ($rose(rst_n)
        |-> st.fine == `OCR_RST_FINE) else $error("fine reset wrong");

    a_page_hold: assert property (i_req.wr && i_req.addr == `OCR_OFS_PAGE
        |=> o_page == $past(i_req.wdata)) else $error("page not stored");

    a_page_flag: assert property (i_req.wr && i_req.addr == `OCR_OFS_PAGE
        && i_req.wdata == 8'h02 |=> o_page_rsvd) else $error("page 02 not flagged");

    a_page_legal: assert property (i_req.wr && i_req.addr == `OCR_OFS_PAGE
        && i_req.wdata == `OCR_PG_IRQ |=> !o_page_rsvd) else $error("page 0F flagged");

    a_mode_ref0: assert property (i_req.wr && i_req.addr == `OCR_OFS_MODE_LO
        |=> o_ref_mode[0] == ocr_ref_mode_e'($past(i_req.wdata[1:0])))
        else $error("ref0 mode wrong");

    a_mode_ref1: assert property (i_req.wr && i_req.addr == `OCR_OFS_MODE_LO
        |=> o_ref_mode[1] == ocr_ref_mode_e'($past(i_req.wdata[3:2])))
        else $error("ref1 mode wrong");

    a_mode_ref2: assert property (i_req.wr && i_req.addr == `OCR_OFS_MODE_LO
        |=> o_ref_mode[2] == ocr_ref_mode_e'($past(i_req.wdata[5:4])))
        else $error("ref2 mode wrong");

    a_mode_ref3: assert property (i_req.wr && i_req.addr == `OCR_OFS_MODE_LO
        && i_req.wdata[7:6] == 2'h3 |=> o_mode_rsvd[3]) else $error("ref3 reserved");

    a_mode_ref4: assert property (i_req.wr && i_req.addr == `OCR_OFS_MODE_HI
        && i_req.wdata[1:0] == 2'h3 |=> o_mode_rsvd[4]) else $error("ref4 reserved");

    a_group_bit: assert property (i_req.wr && i_req.addr == `OCR_OFS_GROUP
        |=> o_low_group == $past(i_req.wdata[0])) else $error("group not taken");

    a_group_reset: assert property ($rose(rst_n)
        |-> !o_low_group) else $error("group reset wrong");

    // read data stand one cycle only
    a_read_once: assert property (!i_req.rd |=> o_rdata == 8'h00)
        else $error("read data linger");

    // read data carry the addressed byte
    a_rdata_fine: assert property (i_req.rd && i_req.addr == `OCR_OFS_FINE
        |=> o_rdata == $past(st.fine)) else $error("fine read wrong");
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ocr_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic                  clk;         // 100 MHz bench clock
    logic                  rst_b;       // reset, active low
    ocr_req_s              req;         // host request
    logic [7:0]            rdata;       // read data
    ocr_diff_s             diff;        // diff pin triple
    logic signed [7:0]     apll_fine;   // analog path phase
    logic signed [7:0]     synth_fine;  // synthesizer phase
    logic [7:0]            page;        // selected page
    logic                  page_rsvd;   // page flagged reserved
    ocr_ref_mode_e [4:0]   ref_mode;    // per reference mode
    logic [4:0]            mode_rsvd;   // reserved mode flags
    logic                  low_group;   // low speed group
    int                    err_count;   // mismatches
    int                    cmp_count;   // comparisons

    ocr_regs i_ocr_regs (
        .i_ref_clk    (clk),
        .i_rst_b      (rst_b),
        .i_req        (req),
        .o_rdata      (rdata),
        .o_diff       (diff),
        .o_apll_fine  (apll_fine),
        .o_synth_fine (synth_fine),
        .o_page       (page),
        .o_page_rsvd  (page_rsvd),
        .o_ref_mode   (ref_mode),
        .o_mode_rsvd  (mode_rsvd),
        .o_low_group  (low_group)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // compare one value and count it
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // one-cycle write, returns just after the taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    // one-cycle read, data sampled in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // read and compare in one go
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(name, exp, d);
    endtask

    // wait for a level change of the true leg, bounded
    task automatic wait_toggle();
        logic v;
        int   k;
        v = diff.p;
        k = 0;
        while (diff.p === v && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    // cycles the true leg stays at one level
    task automatic meas_half(output int h);
        logic v;
        wait_toggle();
        wait_toggle();
        v = diff.p;
        h = 0;
        do begin
            @(posedge clk);
            #1;
            h++;
        end while (diff.p === v && h < 100);
        chk("diff_n", {7'h00, ~diff.p}, {7'h00, diff.n});
    endtask

    // cycles from an enabling write to the first edge of the true leg
    task automatic latency(input logic [1:0] code, output int lat);
        wr_reg(8'h60, {code, 4'b1000, 1'b0, 1'b1});
        repeat (5) @(posedge clk);
        #1;
        chk("oe_off", 8'h00, {7'h00, diff.oe});
        chk("p_off", 8'h00, {7'h00, diff.p});
        wr_reg(8'h60, {code, 4'b1000, 1'b1, 1'b1});
        chk("oe_on", 8'h01, {7'h00, diff.oe});
        lat = 0;
        while (diff.p === 1'b0 && lat < 100) begin
            @(posedge clk);
            #1;
            lat++;
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        rd_chk("ctrl", 8'h60, 8'hA3);
        rd_chk("freq", 8'h61, 8'h55);
        rd_chk("group", 8'h62, 8'h00);
        rd_chk("fine", 8'h63, 8'hFF);
        rd_chk("page", 8'h64, 8'h00);
        rd_chk("mode_lo", 8'h65, 8'h00);
        rd_chk("mode_hi", 8'h66, 8'h00);
        rd_reg(8'h67, d);
        chk("unmapped", 8'h00, d);
        @(posedge clk);
        #1;
        chk("rdata_idle", 8'h00, rdata);
        chk("oe_reset", 8'h01, {7'h00, diff.oe});
        $display("test reset done");
    endtask

    task automatic t_fine();
        wr_reg(8'h63, 8'h80);
        chk("apll_fine", 8'h80, apll_fine);
        chk("synth_fine", 8'h80, synth_fine);
        wr_reg(8'h63, 8'h7F);
        chk("apll_fine", 8'h7F, apll_fine);
        chk("synth_fine", 8'h7F, synth_fine);
        rd_chk("fine_rb", 8'h63, 8'h7F);
        $display("test fine phase done");
    endtask

    task automatic t_page();
        logic [7:0] pg [8] = '{8'h00, 8'h01, 8'h08, 8'h0A, 8'h0F, 8'h02, 8'h10, 8'hFF};
        for (int i = 0; i < 8; i++) begin
            wr_reg(8'h64, pg[i]);
            chk("page", pg[i], page);
            chk("page_rsvd", {7'h00, i > 4}, {7'h00, page_rsvd});
        end
        wr_reg(8'h64, 8'h00);
        $display("test page done");
    endtask

    task automatic t_modes();
        wr_reg(8'h65, 8'hE4);
        wr_reg(8'h66, 8'h03);
        for (int i = 0; i < 5; i++) begin
            chk("ref_mode", (i == 4) ? 8'h03 : 8'(i), {6'h00, ref_mode[i]});
        end
        chk("mode_rsvd", 8'h18, {3'h0, mode_rsvd});
        wr_reg(8'h66, 8'h01);
        chk("ref4_mode", 8'h01, {6'h00, ref_mode[4]});
        chk("mode_rsvd", 8'h08, {3'h0, mode_rsvd});
        rd_chk("mode_hi_rb", 8'h66, 8'h01);
        $display("test modes done");
    endtask

    task automatic t_freq();
        int h;
        meas_half(h);
        chk("half_reset", 8'd6, 8'(h));
        wr_reg(8'h61, {1'b0, 3'h2, 4'h5});
        meas_half(h);
        chk("half_sel2", 8'd3, 8'(h));
        wr_reg(8'h62, 8'h01);
        chk("low_group", 8'h01, {7'h00, low_group});
        meas_half(h);
        chk("half_low", 8'd11, 8'(h));
        $display("test frequency done");
    endtask

    task automatic t_align();
        int l0;
        int l3;
        latency(2'h0, l0);
        latency(2'h3, l3);
        chk("adjust_span", 8'd3, 8'(l3 - l0));
        chk("adjust_order", 8'h01, {7'h00, l0 < l3});
        $display("test alignment done");
    endtask

    // reset in mid-run brings changed ctrl, fine, group and mode_lo registers back
    task automatic t_rst_mid();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("oe_rst_mid", 8'h01, {7'h00, diff.oe});
        chk("fine_rst_mid", 8'hFF, apll_fine);
        chk("group_rst_mid", 8'h00, {7'h00, low_group});
        rd_chk("ctrl_rst_mid", 8'h60, 8'hA3);
        rd_chk("mode_lo_rst_mid", 8'h65, 8'h00);
        $display("test mid-run reset done");
    endtask

    // ----------------------------------------------------------------
    // verdict
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        err_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_fine();
        t_page();
        t_modes();
        t_freq();
        t_align();
        t_rst_mid();
        report_and_stop();
    end

    // cuts a hang short, tests need a few hundred cycles
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end

endmodule

`default_nettype wire
